//--- bench/bsl_board.sv
// Board strap resistors seen on the six shared pins
module bsl_board (
  input wire logic [5:0] pin_o_i,
  input wire logic [5:0] pin_oe_i,
  input wire logic [5:0] strap_i,
  output logic [5:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin wins; a released pin falls to its strap pull
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level_o[i] = pin_oe_i[i] ? pin_o_i[i] : strap_i[i];
    end
  end
endmodule // bsl_board

//--- bench/test_bsl_top.sv
// Self-checking bench for the boot strap latch
module test_bsl_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic ack, err, bvalid, udb, lowm, highm;
  logic [5:0] pin_lvl, pin_o, pin_oe;
  logic [5:0] maddr = 6'h00;
  logic [5:0] straps = 6'h0d;
  logic [1:0] bsel, ba0;
  int fail_count = 0;
  int comparisons = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  bsl_top bsl_top_inst (.CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat),
    .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .ERR_O(err),
    .PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .MEM_ADDR_I(maddr),
    .BOOT_SEL_O(bsel), .BOOT_VALID_O(bvalid), .UPPER_DATA_BYTE_MUX_O(udb),
    .BANK_ADDR_ZERO_MUX_O(ba0), .LOW_ADDR_MUX_O(lowm), .HIGH_ADDR_MUX_O(highm));
  bsl_board bsl_board_inst (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .strap_i(straps),
    .level_o(pin_lvl));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack or err
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    adr <= {24'h0, a};
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      chk(0, 1, "bus timeout");
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  // Power-on reset with a chosen strap set, then wait for capture
  task automatic t_capture(input logic [5:0] s);
    int n;
    logic [31:0] q;
    logic e;
    straps <= s;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(8'h04, 1'b1, 32'h0000_3f1f, q, e);
    chk(e, 0, "early write ack");
    n = 0;
    while (bvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(bvalid, 1, "capture");
    if (n >= 50) tally_and_finish();
    @(posedge clk);
    chk(bsel, s[5:4], "boot sel");
    chk(udb, s[3], "udb mux");
    chk(ba0, s[2:1], "ba0 mux");
    chk({lowm, highm}, {2{s[0]}}, "addr mux");
    wb(8'h00, 1'b0, 0, q, e);
    chk(q, {23'h0, 1'b1, s[3:0], 2'b00, s[5:4]}, "strap reg");
    wb(8'h04, 1'b0, 0, q, e);
    chk(q, {18'h0, 6'h00, 3'h0, s[0], s[0], s[2:1], s[3]}, "mux reg");
    $display("test capture %h done", s);
  endtask
  // Pins take address role, then general I/O role
  task automatic t_pins();
    logic [31:0] q;
    logic e;
    maddr <= 6'h2a;
    repeat (3) @(posedge clk);
    chk(pin_oe, 6'h3f, "addr oe");
    chk(pin_o, 6'h2a, "addr out");
    wb(8'h04, 1'b1, {18'h0, 6'h3f, 8'h0d}, q, e);
    wb(8'h08, 1'b1, {18'h0, 6'h0f, 8'h15}, q, e);
    repeat (3) @(posedge clk);
    chk(pin_oe, 6'h0f, "gpio oe");
    chk(pin_o[3:0], 4'h5, "gpio out");
    chk({udb, ba0, lowm, highm}, 5'h1a, "mux outs");
    wb(8'h04, 1'b0, 0, q, e);
    chk(q, 32'h0000_3f0d, "mux write");
    $display("test pins done");
  endtask
  // Pin activity and writes leave the captured straps alone
  task automatic t_latch();
    logic [31:0] q;
    logic e;
    straps <= 6'h32;
    wb(8'h00, 1'b1, 32'hffff_ffff, q, e);
    repeat (4) @(posedge clk);
    wb(8'h0c, 1'b0, 0, q, e);
    chk(q, 32'h0000_0035, "pin in");
    chk(bsel, 2'b00, "boot held");
    wb(8'h00, 1'b0, 0, q, e);
    chk(q, 32'h0000_01d0, "strap held");
    wb(8'h10, 1'b0, 0, q, e);
    chk(e, 1, "unmapped err");
    $display("test latch done");
  endtask
  // Main sequence
  initial begin
    t_capture(6'h0d);
    t_pins();
    t_latch();
    t_capture(6'h32);
    tally_and_finish();
  end
endmodule // test_bsl_top

//--- design/bsl_pkg.sv
// Package of constants for the boot strap latch
package bsl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STRAP = 8'h00;
  localparam logic [7:0] OFS_MUX = 8'h04;
  localparam logic [7:0] OFS_PINOUT = 8'h08;
  localparam logic [7:0] OFS_PININ = 8'h0c;
  // Field positions in the mux select register
  localparam int MUX_UDB_POS = 0;
  localparam int MUX_BA0_POS = 1;
  localparam int MUX_LOW_POS = 3;
  localparam int MUX_HIGH_POS = 4;
  localparam int MUX_GPIO_POS = 8;
  // Field positions in the strap register
  localparam int STRAP_BOOT_POS = 0;
  localparam int STRAP_CFG_POS = 4;
  localparam int STRAP_DONE_POS = 8;
  // Widths
  localparam int NPIN = 6;
  localparam int BOOT_W = 2;
  localparam int CFG_W = 4;
  // Reset values
  localparam logic [31:0] PINOUT_RST = 32'h0000_0000;
  localparam logic [5:0] GPIO_SEL_RST = 6'h00;
  // Settle time after reset release before the pins are sampled
  localparam int SETTLE_NS = 40;
  localparam int CLK_NS = 10;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // Sequencer states
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } bsl_state_t;
endpackage : bsl_pkg

//--- design/bsl_sync.sv
// Two flip-flop synchroniser for the shared strap pins
module bsl_sync (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] d_i,
  output logic [5:0] q_o
);
  logic [5:0] meta;

  // First stage feeds only the second
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meta <= 6'h00;
      q_o <= 6'h00;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // bsl_sync

//--- design/bsl_top.sv
// Boot strap latch with pin mux and Wishbone register port
// Function
// RULE_01: Sample two boot select straps at power-on reset; drive boot method output.
// RULE_02: Sample four memory config straps at power-on reset as memory interface defaults.
// RULE_03: Top config bit becomes reset default of upper data byte mux (16/8 bit).
// RULE_04: Middle two config bits become reset default of bank address zero mux.
// RULE_05: Low config bit becomes default of both low and high address mux fields.
// RULE_06: After capture, drive six shared pins as address 13..8 or general I/O.
// RULE_07: Captured straps stay latched, unaffected by pin activity, until next power-on.
//
// Our own choices: the register addresses and the Wishbone register port.
module bsl_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [31:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic ACK_O,
  output logic ERR_O,
  input wire logic [5:0] PIN_I,
  output logic [5:0] PIN_O,
  output logic [5:0] PIN_OE_O,
  input wire logic [5:0] MEM_ADDR_I,
  output logic [1:0] BOOT_SEL_O,
  output logic BOOT_VALID_O,
  output logic UPPER_DATA_BYTE_MUX_O,
  output logic [1:0] BANK_ADDR_ZERO_MUX_O,
  output logic LOW_ADDR_MUX_O,
  output logic HIGH_ADDR_MUX_O
);
  bsl_pkg::bsl_state_t state;
  bsl_pkg::bsl_state_t next_state;
  logic [5:0] pin_sync;
  logic [3:0] settle_cnt;
  logic done;
  logic [1:0] boot_select_strap;
  logic [3:0] memif_config_strap;
  logic upper_data_byte_mux;
  logic [1:0] bank_addr_zero_mux;
  logic low_addr_mux;
  logic high_addr_mux;
  logic [5:0] gpio_sel;
  logic [5:0] gpio_out;
  logic [5:0] gpio_oe;
  logic bus_req;
  logic [31:0] rd_data;
  logic addr_ok;

  // Byte-lane merge for a 32-bit write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  bsl_sync bsl_sync_inst (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .d_i(PIN_I),
    .q_o(pin_sync)
  );

  // Sequencer: settle, capture once, then run
  always_comb begin
    next_state = state;
    case (state)
      bsl_pkg::ST_SETTLE: begin
        if (settle_cnt == bsl_pkg::SETTLE_CYC) begin
          next_state = bsl_pkg::ST_CAPTURE;
        end
      end
      bsl_pkg::ST_CAPTURE: next_state = bsl_pkg::ST_RUN;
      bsl_pkg::ST_RUN: next_state = bsl_pkg::ST_RUN;
      default: next_state = bsl_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= bsl_pkg::ST_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  // Settle counter covers the synchroniser delay
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      settle_cnt <= 4'h0;
    end else if (state == bsl_pkg::ST_SETTLE) begin
      settle_cnt <= settle_cnt + 4'h1;
    end
  end

  // Strap capture, held until the next reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      boot_select_strap <= 2'h0;
      memif_config_strap <= 4'h0;
      done <= 1'b0;
    end else if (state == bsl_pkg::ST_CAPTURE) begin
      boot_select_strap <= pin_sync[5:4]; // [RULE_01] [RULE_07]
      memif_config_strap <= pin_sync[3:0]; // [RULE_02] [RULE_07]
      done <= 1'b1;
    end
  end

  // Bus handshake
  assign bus_req = CYC_I & STB_I & ~ACK_O & ~ERR_O;
  assign addr_ok = (ADR_I[7:0] == bsl_pkg::OFS_STRAP) || (ADR_I[7:0] == bsl_pkg::OFS_MUX) ||
                   (ADR_I[7:0] == bsl_pkg::OFS_PINOUT) || (ADR_I[7:0] == bsl_pkg::OFS_PININ);

  // Mux fields: strap defaults at capture (pin select keeps its reset value), software writes afterwards
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      upper_data_byte_mux <= 1'b0;
      bank_addr_zero_mux <= 2'h0;
      low_addr_mux <= 1'b0;
      high_addr_mux <= 1'b0;
      gpio_sel <= bsl_pkg::GPIO_SEL_RST;
    end else if (state == bsl_pkg::ST_CAPTURE) begin
      upper_data_byte_mux <= pin_sync[3]; // [RULE_03]
      bank_addr_zero_mux <= pin_sync[2:1]; // [RULE_04]
      low_addr_mux <= pin_sync[0]; // [RULE_05]
      high_addr_mux <= pin_sync[0]; // [RULE_05]
    end else if (bus_req && WE_I && done && ADR_I[7:0] == bsl_pkg::OFS_MUX) begin
      if (SEL_I[0]) begin
        upper_data_byte_mux <= DAT_I[bsl_pkg::MUX_UDB_POS];
        bank_addr_zero_mux <= DAT_I[bsl_pkg::MUX_BA0_POS +: 2];
        low_addr_mux <= DAT_I[bsl_pkg::MUX_LOW_POS];
        high_addr_mux <= DAT_I[bsl_pkg::MUX_HIGH_POS];
      end
      if (SEL_I[1]) begin
        gpio_sel <= DAT_I[bsl_pkg::MUX_GPIO_POS +: 6];
      end
    end
  end

  // General I/O output data and enables
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gpio_out <= bsl_pkg::PINOUT_RST[5:0];
      gpio_oe <= bsl_pkg::PINOUT_RST[13:8];
    end else if (bus_req && WE_I && ADR_I[7:0] == bsl_pkg::OFS_PINOUT) begin
      if (SEL_I[0]) begin
        gpio_out <= DAT_I[5:0];
      end
      if (SEL_I[1]) begin
        gpio_oe <= DAT_I[13:8];
      end
    end
  end

  // Pins float during sampling, then take their functional role
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PIN_O <= 6'h00;
      PIN_OE_O <= 6'h00;
    end else if (!done) begin
      PIN_O <= 6'h00;
      PIN_OE_O <= 6'h00;
    end else begin
      for (int i = 0; i < bsl_pkg::NPIN; i++) begin
        PIN_O[i] <= gpio_sel[i] ? gpio_out[i] : MEM_ADDR_I[i]; // [RULE_06]
        PIN_OE_O[i] <= gpio_sel[i] ? gpio_oe[i] : 1'b1; // [RULE_06]
      end
    end
  end

  // Configuration outputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BOOT_SEL_O <= 2'h0;
      BOOT_VALID_O <= 1'b0;
      UPPER_DATA_BYTE_MUX_O <= 1'b0;
      BANK_ADDR_ZERO_MUX_O <= 2'h0;
      LOW_ADDR_MUX_O <= 1'b0;
      HIGH_ADDR_MUX_O <= 1'b0;
    end else begin
      BOOT_SEL_O <= boot_select_strap; // [RULE_01]
      BOOT_VALID_O <= done;
      UPPER_DATA_BYTE_MUX_O <= upper_data_byte_mux;
      BANK_ADDR_ZERO_MUX_O <= bank_addr_zero_mux;
      LOW_ADDR_MUX_O <= low_addr_mux;
      HIGH_ADDR_MUX_O <= high_addr_mux;
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (ADR_I[7:0])
      bsl_pkg::OFS_STRAP: begin
        rd_data[bsl_pkg::STRAP_BOOT_POS +: 2] = boot_select_strap;
        rd_data[bsl_pkg::STRAP_CFG_POS +: 4] = memif_config_strap;
        rd_data[bsl_pkg::STRAP_DONE_POS] = done;
      end
      bsl_pkg::OFS_MUX: begin
        rd_data[bsl_pkg::MUX_UDB_POS] = upper_data_byte_mux;
        rd_data[bsl_pkg::MUX_BA0_POS +: 2] = bank_addr_zero_mux;
        rd_data[bsl_pkg::MUX_LOW_POS] = low_addr_mux;
        rd_data[bsl_pkg::MUX_HIGH_POS] = high_addr_mux;
        rd_data[bsl_pkg::MUX_GPIO_POS +: 6] = gpio_sel;
      end
      bsl_pkg::OFS_PINOUT: begin
        rd_data = merge(32'h0000_0000, {18'h00000, gpio_oe, 2'h0, gpio_out}, 4'hf);
      end
      bsl_pkg::OFS_PININ: rd_data[5:0] = pin_sync;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Wishbone answer: one cycle after the request, error on unmapped
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= bus_req & addr_ok;
      ERR_O <= bus_req & ~addr_ok;
      DAT_O <= (bus_req && !WE_I && addr_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // Straps hold once captured
  strap_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_07]
    done && $past(done) |-> $stable(boot_select_strap) && $stable(memif_config_strap))
    else $error("strap value changed after capture");
  // Boot select taken from pins at capture
  boot_capture_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_01]
    state == bsl_pkg::ST_CAPTURE |=> boot_select_strap == $past(pin_sync[5:4]) ##1
    BOOT_SEL_O == boot_select_strap)
    else $error("boot select not captured");
  // Config taken at capture
  cfg_capture_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_02]
    state == bsl_pkg::ST_CAPTURE |=> memif_config_strap == $past(pin_sync[3:0]) && done)
    else $error("config not captured");
  // Upper data byte default
  udb_default_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_03]
    $rose(done) |-> upper_data_byte_mux == memif_config_strap[3])
    else $error("upper byte default wrong");
  // Bank address default
  ba0_default_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_04]
    $rose(done) |-> bank_addr_zero_mux == memif_config_strap[2:1])
    else $error("bank address default wrong");
  // Address width defaults
  addr_default_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_05]
    $rose(done) |-> low_addr_mux == memif_config_strap[0] &&
    high_addr_mux == memif_config_strap[0])
    else $error("address width default wrong");
  // Pins undriven during sampling
  pin_float_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_06]
    !done |=> PIN_OE_O == 6'h00)
    else $error("pins driven before capture");
  // Address role drives the pin
  pin_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_06]
    done && gpio_sel == 6'h00 |=> PIN_OE_O == 6'h3f && PIN_O == $past(MEM_ADDR_I))
    else $error("address role not driven");
  // General I/O role drives the pin from the output registers
  pin_gpio_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_06]
    done && gpio_sel == 6'h3f |=> PIN_OE_O == $past(gpio_oe) && PIN_O == $past(gpio_out))
    else $error("gpio role not driven");
  // Boot select output matches the latched straps once valid
  boot_out_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_01]
    BOOT_VALID_O |-> BOOT_SEL_O == boot_select_strap)
    else $error("boot select output differs from latch");
  // Upper byte and bank address outputs follow their fields
  mux_out_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_03] [RULE_04]
    $past(done) |-> UPPER_DATA_BYTE_MUX_O == $past(upper_data_byte_mux) &&
    BANK_ADDR_ZERO_MUX_O == $past(bank_addr_zero_mux))
    else $error("mux output lags its field");
  // Address width outputs follow their fields
  addr_out_a: assert property (@(posedge CLK_I) disable iff (RST_I) // [RULE_05]
    $past(done) |-> LOW_ADDR_MUX_O == $past(low_addr_mux) &&
    HIGH_ADDR_MUX_O == $past(high_addr_mux))
    else $error("address width output lags its field");
  // Pin select ignores writes until the straps are in
  mux_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !done |=> $stable(gpio_sel))
    else $error("pin select written before capture");
  // Mapped request answered with ack in the next cycle
  ack_next_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bus_req && addr_ok |=> ACK_O && !ERR_O)
    else $error("mapped request not acked");
  // Unmapped request answered with error and no ack
  err_next_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    bus_req && !addr_ok |=> ERR_O && !ACK_O)
    else $error("unmapped request not refused");
  // Answers last a single cycle
  ack_pulse_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ACK_O || ERR_O |=> !ACK_O && !ERR_O)
    else $error("answer held too long");
  // Read data stays zero outside an ack
  dat_idle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !ACK_O |-> DAT_O == 32'h0000_0000)
    else $error("read data outside ack");
endmodule // bsl_top
